// *** hdl/tmd_pkg.sv ***
// Shared constants for the transceiver management and diagnostics port.
// Assumes a 20 MHz system clock and a host-driven two-wire serial link.
package tmd_pkg;
   localparam int TMD_ADDR_W = 8;
   localparam int TMD_DATA_W = 8;
   localparam logic [6:0] TMD_DEV_ADDR = 7'h50;
   localparam logic [7:0] TMD_PROT_BASE = 8'h00;
   localparam logic [7:0] TMD_PROT_TOP = 8'h5F;
   localparam logic [7:0] TMD_RST_BYTE = 8'h00;
   localparam logic [7:0] TMD_RST_PTR = 8'h00;
   localparam logic [3:0] TMD_BIT_LAST = 4'h7;
   localparam logic [3:0] TMD_BIT_ACK = 4'h8;
   localparam logic [7:0] TMD_OFS_TEMP = 8'h60;
   localparam logic [7:0] TMD_OFS_BIAS = 8'h61;
   localparam logic [7:0] TMD_OFS_TXPWR = 8'h62;
   localparam logic [7:0] TMD_OFS_RXPWR = 8'h63;
   localparam logic [7:0] TMD_OFS_VCC = 8'h64;
   localparam logic [7:0] TMD_OFS_FLAGS = 8'h65;
   localparam logic [7:0] TMD_OFS_LIMIT = 8'h00;
   localparam logic [2:0] TMD_NUM_MON = 3'h5;
endpackage

// *** hdl/tmd_mgmt_port.sv ***
// Management port of a pluggable transceiver: control pins and a two-wire
// serial slave over an 8-bit diagnostics memory.
// Assumes the host drives the serial clock; the serial engine runs on that clock.
// Behaviour
// - Serial traffic answered only while deselect low.
// - Interrupt low while any alarm condition exists.
// - Laser-off input turns transmitter off.
// - Loss output high on lost receive signal.
// - Presence output tied permanently low.
// - Not-ready output flags operational fault.
// - Power-down high enters low-power mode.
// - Serial port stays working in low power.
// - Power-down falling edge resets module state; pin synchronisers are not reset.
// - Monitored readings readable over serial port.
// - Alarm flags set outside normal range.
// - Sample on rising edge; skip protected writes.
// - Launch read data on falling edges.
// - Data line bidirectional; host frames transactions.
// - Memory of 8-bit words, random and sequential.
`timescale 1ns/10ps
`default_nettype none
module tmd_mgmt_port
   import tmd_pkg::*;
#(
   parameter int DEPTH = 256
) (
   // System clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Control and status pins.
   input wire logic i_desel,
   input wire logic i_laser_off_in,
   input wire logic i_pdown_rst,
   input wire logic i_rx_signal_lost,
   input wire logic i_fault,
   output logic o_int_n,
   output logic o_tx_enable,
   output logic o_rx_signal_lost,
   output logic o_present_n,
   output logic o_not_ready_out,
   output logic o_low_power,
   // Monitor readings from the analogue front end.
   input wire logic [7:0] i_mon_temp,
   input wire logic [7:0] i_mon_bias,
   input wire logic [7:0] i_mon_txpwr,
   input wire logic [7:0] i_mon_rxpwr,
   input wire logic [7:0] i_mon_vcc,
   // Two-wire serial link, clock pin is the link clock.
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe_n
);
   typedef enum logic [2:0] {
      TMD_IDLE = 3'b000,
      TMD_DEV = 3'b001,
      TMD_PTR = 3'b010,
      TMD_WR = 3'b011,
      TMD_RD = 3'b100
   } tmd_state_t;

   // System domain: pin synchronisers and module reset.
   logic [1:0] pd_sync;
   logic [1:0] ds_sync;
   logic [1:0] lo_sync;
   logic [1:0] los_sync;
   logic [1:0] flt_sync;
   logic pd_prev;
   logic next_pd_prev;
   logic mod_rst_n;
   logic next_mod_rst_n;
   logic [7:0] mon [0:4];
   logic [4:0] alarm;
   logic alarm_any;

   always_comb begin
      next_pd_prev = pd_sync[1];
      // A falling power-down edge behaves like a power cycle.
      next_mod_rst_n = !(pd_prev && !pd_sync[1]);
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pd_sync <= 2'h0;
         ds_sync <= 2'h3;
         lo_sync <= 2'h3;
         los_sync <= 2'h0;
         flt_sync <= 2'h0;
         pd_prev <= 1'b0;
         mod_rst_n <= 1'b0;
      end else begin
         pd_sync <= {pd_sync[0], i_pdown_rst};
         ds_sync <= {ds_sync[0], i_desel};
         lo_sync <= {lo_sync[0], i_laser_off_in};
         los_sync <= {los_sync[0], i_rx_signal_lost};
         flt_sync <= {flt_sync[0], i_fault};
         pd_prev <= next_pd_prev;
         mod_rst_n <= next_mod_rst_n;
      end
   end

   always_comb begin
      mon[0] = i_mon_temp;
      mon[1] = i_mon_bias;
      mon[2] = i_mon_txpwr;
      mon[3] = i_mon_rxpwr;
      mon[4] = i_mon_vcc;
   end

   // Limits live in protected memory written at the factory.
   logic [7:0] mem [0:DEPTH-1];
   logic [7:0] lo_lim [0:4];
   logic [7:0] hi_lim [0:4];
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_mon
         assign lo_lim[g] = mem[TMD_OFS_LIMIT + 8'(2 * g)];
         assign hi_lim[g] = mem[TMD_OFS_LIMIT + 8'(2 * g + 1)];
         assign alarm[g] = (mon[g] < lo_lim[g]) || (mon[g] > hi_lim[g]);
      end
   endgenerate

   logic [4:0] alarm_q;
   logic int_n;
   logic next_int_n;
   always_comb begin
      alarm_any = |alarm;
      next_int_n = !(alarm_any || flt_sync[1]);
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || !mod_rst_n) begin
         alarm_q <= 5'h00;
         int_n <= 1'b1;
      end else begin
         alarm_q <= alarm;
         int_n <= next_int_n;
      end
   end

   always_comb begin
      o_int_n = int_n;
      o_tx_enable = !lo_sync[1] && !pd_sync[1];
      o_rx_signal_lost = los_sync[1];
      o_present_n = 1'b0;
      o_not_ready_out = flt_sync[1];
      o_low_power = pd_sync[1];
   end

   // Link domain. Deselect and module reset cross in as levels.
   logic [1:0] l_ds_sync;
   logic [1:0] l_rst_sync;
   logic l_sel;
   logic l_rst_n;
   logic rst_req_n;
   always_ff @(posedge i_scl) begin
      l_ds_sync <= {l_ds_sync[0], ds_sync[1]};
   end
   // The reset pulse lasts one system cycle while the link clock may stand still,
   // so it enters asynchronously and leaves on the link clock.
   always_ff @(posedge i_scl or negedge rst_req_n) begin
      if (!rst_req_n) begin
         l_rst_sync <= 2'h0;
      end else begin
         l_rst_sync <= {l_rst_sync[0], 1'b1};
      end
   end
   always_comb begin
      rst_req_n = mod_rst_n && i_rst_n;
      l_sel = !l_ds_sync[1];
      l_rst_n = l_rst_sync[1];
   end

   // Start and stop are seen on data edges while the clock is high.
   // The serial port keeps running in low power; no power gating here.
   logic start_tgl;
   logic stop_tgl;
   always_ff @(negedge i_sda or negedge l_rst_n) begin
      if (!l_rst_n) begin
         start_tgl <= 1'b0;
      end else if (i_scl) begin
         start_tgl <= !start_tgl;
      end
   end
   always_ff @(posedge i_sda or negedge l_rst_n) begin
      if (!l_rst_n) begin
         stop_tgl <= 1'b0;
      end else if (i_scl) begin
         stop_tgl <= !stop_tgl;
      end
   end
   logic start_seen;
   logic stop_seen;
   logic next_start_seen;
   logic next_stop_seen;
   logic busy;
   logic next_busy;
   always_comb begin
      next_start_seen = start_tgl;
      next_stop_seen = stop_tgl;
   end

   tmd_state_t st;
   tmd_state_t next_st;
   logic [3:0] bitc;
   logic [3:0] next_bitc;
   logic [7:0] shreg;
   logic [7:0] next_shreg;
   logic [7:0] ptr;
   logic [7:0] next_ptr;
   logic rd_mode;
   logic next_rd_mode;
   logic ack_ok;
   logic next_ack_ok;
   logic wr_en;
   logic [7:0] rd_byte;
   logic new_start;
   logic new_stop;

   always_comb begin
      new_start = (start_tgl != start_seen);
      new_stop = (stop_tgl != stop_seen);
      next_busy = busy;
      next_st = st;
      next_bitc = bitc;
      next_shreg = shreg;
      next_ptr = ptr;
      next_rd_mode = rd_mode;
      next_ack_ok = ack_ok;
      wr_en = 1'b0;
      if (new_stop) begin
         next_busy = 1'b0;
         next_st = TMD_IDLE;
      end
      if (new_start) begin
         next_busy = l_sel;
         next_st = l_sel ? TMD_DEV : TMD_IDLE;
         next_bitc = 4'h0;
         next_shreg = {7'h00, i_sda};
         next_bitc = 4'h1;
         next_ack_ok = 1'b0;
      end else if (st != TMD_IDLE) begin
         if (bitc <= TMD_BIT_LAST) begin
            next_shreg = {shreg[6:0], i_sda};
            next_bitc = bitc + 4'h1;
         end else begin
            next_bitc = 4'h0;
            next_shreg = 8'h00;
            case (st)
               TMD_DEV: begin
                  if (shreg[7:1] == TMD_DEV_ADDR) begin
                     next_rd_mode = shreg[0];
                     next_st = shreg[0] ? TMD_RD : TMD_PTR;
                  end else begin
                     next_st = TMD_IDLE;
                  end
               end
               TMD_PTR: begin
                  next_ptr = shreg;
                  next_st = TMD_WR;
               end
               TMD_WR: begin
                  wr_en = (ptr < TMD_PROT_BASE) || (ptr > TMD_PROT_TOP);
                  next_ptr = ptr + 8'h01;
               end
               TMD_RD: begin
                  next_ptr = ptr + 8'h01;
                  if (i_sda) begin
                     next_st = TMD_IDLE;
                  end
               end
               default: next_st = TMD_IDLE;
            endcase
         end
      end
      next_ack_ok = (next_st == TMD_PTR || next_st == TMD_WR || next_st == TMD_RD);
   end

   always_ff @(posedge i_scl) begin
      if (!l_rst_n) begin
         st <= TMD_IDLE;
         bitc <= 4'h0;
         shreg <= TMD_RST_BYTE;
         ptr <= TMD_RST_PTR;
         rd_mode <= 1'b0;
         ack_ok <= 1'b0;
         busy <= 1'b0;
         start_seen <= 1'b0;
         stop_seen <= 1'b0;
      end else begin
         st <= next_st;
         bitc <= next_bitc;
         shreg <= next_shreg;
         ptr <= next_ptr;
         rd_mode <= next_rd_mode;
         ack_ok <= next_ack_ok;
         busy <= next_busy;
         start_seen <= next_start_seen;
         stop_seen <= next_stop_seen;
      end
   end

   // Memory write port on the link clock; monitored values are mirrored on read.
   // A module reset clears the memory, as a power cycle would.
   always_ff @(posedge i_scl) begin
      if (!l_rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= TMD_RST_BYTE;
         end
      end else if (wr_en) begin
         mem[ptr] <= shreg;
      end
   end

   always_comb begin
      case (ptr)
         TMD_OFS_TEMP: rd_byte = i_mon_temp;
         TMD_OFS_BIAS: rd_byte = i_mon_bias;
         TMD_OFS_TXPWR: rd_byte = i_mon_txpwr;
         TMD_OFS_RXPWR: rd_byte = i_mon_rxpwr;
         TMD_OFS_VCC: rd_byte = i_mon_vcc;
         TMD_OFS_FLAGS: rd_byte = {3'h0, alarm_q};
         default: rd_byte = mem[ptr];
      endcase
   end

   // Output drive changes on the falling clock so the host samples it stable.
   logic sda_low;
   logic next_sda_low;
   always_comb begin
      next_sda_low = 1'b0;
      if (st == TMD_RD && bitc <= TMD_BIT_LAST) begin
         next_sda_low = !rd_byte[3'(TMD_BIT_LAST - bitc)];
      end else if (bitc == TMD_BIT_ACK && (st == TMD_DEV || st == TMD_PTR || st == TMD_WR)) begin
         next_sda_low = (st != TMD_DEV) || (shreg[7:1] == TMD_DEV_ADDR);
      end
   end
   always_ff @(negedge i_scl or negedge l_rst_n) begin
      if (!l_rst_n) begin
         sda_low <= 1'b0;
      end else begin
         sda_low <= next_sda_low && l_sel;
      end
   end
   always_comb begin
      o_sda = 1'b0;
      o_sda_oe_n = !sda_low;
   end
endmodule
`default_nettype wire

// *** tb/tmd_mgmt_port_chk.sv ***
// Pin-level assertions for the management port.
// Bound to every tmd_mgmt_port instance; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module tmd_mgmt_port_chk (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Watched pins.
   input wire logic i_desel,
   input wire logic i_laser_off_in,
   input wire logic i_pdown_rst,
   input wire logic i_rx_signal_lost,
   input wire logic i_fault,
   input wire logic o_int_n,
   input wire logic o_tx_enable,
   input wire logic o_rx_signal_lost,
   input wire logic o_present_n,
   input wire logic o_not_ready_out,
   input wire logic o_low_power,
   input wire logic o_sda,
   input wire logic o_sda_oe_n
);
   logic [3:0] desel_cnt, next_desel_cnt;
   always_comb begin
      next_desel_cnt = (desel_cnt == 4'hF) ? desel_cnt : desel_cnt + 4'h1;
      if (!i_desel) next_desel_cnt = 4'h0;
   end
   always_ff @(posedge i_clk) desel_cnt <= i_rst_n ? next_desel_cnt : 4'h0;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_tied_pins: assert property (!o_present_n && !o_sda)
      else $error("Tied pin changed.");
   a_desel_quiet: assert property (desel_cnt >= 4'h8 |-> o_sda_oe_n)
      else $error("Data line driven while deselected.");
   a_laser_cuts: assert property ($rose(i_laser_off_in) |-> ##[1:4] !o_tx_enable)
      else $error("Transmitter not turned off.");
   a_tx_restore: assert property ((!i_laser_off_in && !i_pdown_rst)[*8] |-> o_tx_enable)
      else $error("Transmitter not enabled.");
   a_pdown_enter: assert property (i_pdown_rst[*5] |-> o_low_power && !o_tx_enable)
      else $error("Low power not entered.");
   a_pdown_exit: assert property (!i_pdown_rst[*8] |-> !o_low_power)
      else $error("Low power not left.");
   a_loss_follow: assert property ($stable(i_rx_signal_lost)[*5] |->
      o_rx_signal_lost == i_rx_signal_lost)
      else $error("Loss output wrong.");
   a_fault_follow: assert property ($stable(i_fault)[*5] |-> o_not_ready_out == i_fault)
      else $error("Not-ready output wrong.");
   a_fault_int: assert property (i_fault[*5] |-> !o_int_n)
      else $error("Interrupt not raised.");
   c_dev_drive: cover property (!o_sda_oe_n);
   c_pdown_fall: cover property ($fell(i_pdown_rst));
   c_laser_off: cover property (i_laser_off_in && !o_tx_enable);
endmodule
bind tmd_mgmt_port tmd_mgmt_port_chk chk (.*);
`default_nettype wire

// *** tb/tmd_host.sv ***
// Two-wire bus master standing in for the host board controller.
// Clock stands high after a stop; idle pulses leave it low; the bench resolves the pulled-up line.
`timescale 1ns/10ps
`default_nettype none
module tmd_host (
   // Serial clock, always made here.
   output logic o_scl,
   // High while the host pulls the data line low.
   output logic o_sda_low,
   // Resolved line level.
   input wire logic i_sda
);
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task start();
      o_sda_low = 1'b0;
      #40 o_scl = 1'b1;
      #40 o_sda_low = 1'b1;
      #40 o_scl = 1'b0;
   endtask
   task stop();
      o_sda_low = 1'b1;
      #40 o_scl = 1'b1;
      #40 o_sda_low = 1'b0;
      #40;
   endtask
   // Data moves only while the clock is low, so no false frame edge.
   task bit_io(input logic b, output logic s);
      o_sda_low = !b;
      #40 o_scl = 1'b1;
      #40 s = i_sda;
      #40 o_scl = 1'b0;
      #40;
   endtask
   task idle(input int n);
      logic s;
      repeat (n) bit_io(1'b1, s);
   endtask
   task wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(d[i], s);
      bit_io(1'b1, ack);
   endtask
   task rbyte(output logic [7:0] d, input logic last);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         d[i] = s;
      end
      bit_io(last, s);
   endtask
endmodule
`default_nettype wire

// *** tb/tb_tmd_mgmt_port.sv ***
// Self-checking bench for the management port.
// Uses tmd_host as bus master; the data line has a pull-up.
`timescale 1ns/10ps
`default_nettype none
module tb_tmd_mgmt_port;
   import tmd_pkg::*;
   logic i_clk, i_rst_n, i_desel, i_laser_off_in, i_pdown_rst, i_rx_signal_lost, i_fault;
   logic [7:0] i_mon_temp, i_mon_bias, i_mon_txpwr, i_mon_rxpwr, i_mon_vcc, d;
   logic o_int_n, o_tx_enable, o_rx_signal_lost, o_present_n, o_not_ready_out, o_low_power;
   logic o_sda, o_sda_oe_n, scl, sda_low, ack;
   int miscompares, n_compared, cyc;
   wire logic sda = sda_low ? 1'b0 : (!o_sda_oe_n ? o_sda : 1'b1);
   tmd_mgmt_port uut (.*, .i_scl(scl), .i_sda(sda));
   tmd_host host (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   task wrap_up();
      $display("compared=%0d mismatches=%0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         wrap_up();
      end
   end
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task pins(input logic l, input logic p, input logic r, input logic f);
      @(posedge i_clk) #1;
      {i_laser_off_in, i_pdown_rst, i_rx_signal_lost, i_fault} = {l, p, r, f};
      repeat (8) @(posedge i_clk);
      #1;
   endtask
   task set_ptr(input logic [7:0] p);
      host.start();
      host.wbyte({TMD_DEV_ADDR, 1'b0}, ack);
      chk(8'(ack), 8'h00);
      host.wbyte(p, ack);
      chk(8'(ack), 8'h00);
   endtask
   task rd_at(input logic [7:0] p);
      set_ptr(p);
      host.start();
      host.wbyte({TMD_DEV_ADDR, 1'b1}, ack);
      chk(8'(ack), 8'h00);
   endtask
   task t_pins();
      pins(1'b1, 1'b0, 1'b1, 1'b1);
      chk(8'(o_tx_enable), 8'h00);
      chk(8'(o_rx_signal_lost), 8'h01);
      chk(8'(o_not_ready_out), 8'h01);
      chk(8'(o_int_n), 8'h00);
      chk(8'(o_present_n), 8'h00);
      pins(1'b0, 1'b0, 1'b0, 1'b0);
      chk({o_tx_enable, o_rx_signal_lost, o_not_ready_out}, 8'h04);
   endtask
   task t_wr_rd();
      set_ptr(8'h70);
      host.wbyte(8'hA5, ack);
      chk(8'(ack), 8'h00);
      host.wbyte(8'h3C, ack);
      host.stop();
      rd_at(8'h70);
      host.rbyte(d, 1'b0);
      chk(d, 8'hA5);
      host.rbyte(d, 1'b1);
      chk(d, 8'h3C);
      host.stop();
   endtask
   task t_protect();
      set_ptr(8'h20);
      host.wbyte(8'h5A, ack);
      host.stop();
      rd_at(8'h20);
      host.rbyte(d, 1'b1);
      chk(d, TMD_RST_BYTE);
      host.stop();
   endtask
   task t_mon();
      {i_mon_temp, i_mon_bias, i_mon_txpwr, i_mon_rxpwr, i_mon_vcc} = 40'h1122334455;
      repeat (8) @(posedge i_clk);
      rd_at(TMD_OFS_TEMP);
      for (int i = 0; i < 5; i++) begin
         host.rbyte(d, i == 4);
         chk(d, 8'(8'h11 * (i + 1)));
      end
      host.stop();
   endtask
   task t_desel();
      @(posedge i_clk) #1 i_desel = 1'b1;
      repeat (10) @(posedge i_clk);
      host.idle(4);
      host.start();
      host.wbyte({TMD_DEV_ADDR, 1'b0}, ack);
      chk(8'(ack), 8'h01);
      host.stop();
      @(posedge i_clk) #1 i_desel = 1'b0;
      repeat (4) @(posedge i_clk);
      host.idle(4);
   endtask
   task t_pdown();
      pins(1'b0, 1'b1, 1'b0, 1'b0);
      chk({o_low_power, o_tx_enable}, 8'h02);
      rd_at(TMD_OFS_TEMP);
      host.rbyte(d, 1'b1);
      chk(d, 8'h11);
      host.stop();
      pins(1'b0, 1'b0, 1'b0, 1'b0);
      host.idle(4);
      chk(8'(o_low_power), 8'h00);
      rd_at(8'h70);
      host.rbyte(d, 1'b1);
      chk(d, TMD_RST_BYTE);
      host.stop();
   endtask
   initial begin
      {i_rst_n, i_desel, i_laser_off_in, i_pdown_rst, i_rx_signal_lost, i_fault} = 6'h00;
      {i_mon_temp, i_mon_bias, i_mon_txpwr, i_mon_rxpwr, i_mon_vcc} = 40'h0;
      // The link reset is taken on the serial clock, so it needs a few pulses.
      host.idle(4);
      @(posedge i_clk) #1 i_rst_n = 1'b1;
      repeat (4) @(posedge i_clk);
      host.idle(4);
      t_pins();
      t_wr_rd();
      t_protect();
      t_mon();
      t_desel();
      t_pdown();
      wrap_up();
   end
endmodule
`default_nettype wire
